/* File: rtl/atpc_pkg.sv */
// Constants, types and helpers of the transmit port control block
package atpc_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned REG_IO_MODE = 0;
  localparam int unsigned REG_GAIN = 1;
  localparam int unsigned REG_DELAY = 7;
  localparam int unsigned REG_FILTER = 8;
  localparam int unsigned REG_RESULT = 9;
  localparam int unsigned REG_STATUS = 10;
  // Field positions
  localparam int unsigned PUMP_EN_BIT = 0;
  localparam int unsigned IO_MODE_LSB = 3;
  localparam int unsigned GAIN_LSB = 0;
  localparam int unsigned DELAY_BIT = 5;
  localparam int unsigned HPF_BYPASS_BIT = 4;
  localparam int unsigned LINEAR_BIT = 5;
  // Values after reset and encodings
  localparam logic PUMP_EN_RESET = 1'b1;
  localparam logic [1:0] IO_MODE_MONITOR = 2'h1;
  localparam logic [7:0] QUIET_WORD = 8'hFF;
  localparam logic [3:0] LEN16 = 4'h2;
  localparam logic [3:0] LEN24 = 4'h3;
  localparam logic [3:0] LEN32 = 4'h4;
  localparam logic [3:0] LEN64 = 4'h8;
  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CONV_HZ = 512_000;
  localparam int unsigned CONV_DIV = CLK_HZ / CONV_HZ;
  localparam int unsigned FRAME_NS = 125_000;
  localparam int unsigned FRAME_CYCLES = FRAME_NS / (1_000_000_000 / CLK_HZ);

  typedef enum logic [1:0] {RATE16 = 2'h0, RATE24 = 2'h1, RATE32 = 2'h2, RATE64 = 2'h3} atpc_rate_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_DRIVE = 2'h2} atpc_tx_t;

  // Enable length to rate; bit 2 flags an unsupported length
  function automatic logic [2:0] atpcLenToRate(input logic [3:0] len);
    case (len)
      LEN16: atpcLenToRate = {1'b0, RATE16};
      LEN24: atpcLenToRate = {1'b0, RATE24};
      LEN32: atpcLenToRate = {1'b0, RATE32};
      LEN64: atpcLenToRate = {1'b0, RATE64};
      default: atpcLenToRate = 3'h4;
    endcase
  endfunction

  function automatic logic [3:0] atpcRateLen(input atpc_rate_t r);
    case (r)
      RATE16: atpcRateLen = LEN16;
      RATE24: atpcRateLen = LEN24;
      RATE32: atpcRateLen = LEN32;
      default: atpcRateLen = LEN64;
    endcase
  endfunction
endpackage

/* File: rtl/atpc_top.sv */
// Transmit serial port, sample FIFO and control registers of the codec
//
// Behaviour
// - Enable length picks each frame's encoding rate
// - One encode per 125 us frame, length sampled
// - Word computed next frame, output two frames later
// - Delay bit adds four frames to rate info
// - Only rate info is delayed, not samples
// - Driver holds word length minus half cycle
// - Three-bit transmit gain, 0 to 7 dB
// - Control bit bypasses transmit high-pass filter
// - Control bit selects 8-bit linear converter output
// - Monitor mode routes supply; result readable
// - Result: don't-care top, seven magnitude bits
// - Charge pump clocked at 256 kHz
// - Differential converter clocked at 512 kHz
// - Receive enable length selects decode rate
// - Quiet input gives all-ones adaptive word
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module atpc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rdPtr;
    logic [AW-1:0]               wrPtr;
    logic [AW:0]                 count;
    logic                        notFull;
  } atpc_fifo_t;
  atpc_fifo_t fifo_reg, fifo_next;
  logic push, pop;

  assign inReady  = fifo_reg.notFull;
  assign outValid = fifo_reg.count != '0;
  assign outData  = fifo_reg.mem[fifo_reg.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    fifo_next = fifo_reg;
    if (push) begin
      fifo_next.mem[fifo_reg.wrPtr] = inData;
      fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      fifo_next.rdPtr = fifo_reg.rdPtr + 1'b1;
    end
    fifo_next.count = fifo_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    fifo_next.notFull = fifo_next.count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fifo_reg <= '0;
      fifo_reg.notFull <= 1'b1;
    end else begin
      fifo_reg <= fifo_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module atpc_top import atpc_pkg::*; #(
  parameter int unsigned FRAME_LIMIT = FRAME_CYCLES + FRAME_CYCLES / 8,
  parameter int unsigned FIFO_DEPTH  = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial data port pins
  input  wire logic        txBitClock,
  input  wire logic        txFrameEnable,
  output logic             txSerialOut,
  output logic             txSerialOutEn_n,
  input  wire logic        rxBitClock,
  input  wire logic        rxFrameEnable,
  // Sample stream from the converter path
  input  wire logic        sampleValid,
  input  wire logic [7:0]  sampleData,
  output logic             sampleReady,
  // Supply monitor converter result
  input  wire logic        adcValid,
  input  wire logic [6:0]  adcMagnitude,
  // Analog control outputs
  output logic             pumpEnable,
  output logic             pumpClkEn,
  output logic             convClkEn,
  output logic [2:0]       txTrimGain,
  output logic             hpfBypass,
  output logic             linearFormat,
  output logic             supplyMonitorSel,
  output logic [1:0]       rxRate
);
  if (FRAME_LIMIT <= FRAME_CYCLES || FRAME_LIMIT >= 2**20) $error("FRAME_LIMIT out of range");
  if (FIFO_DEPTH != 8) $error("FIFO_DEPTH must be 8");

  typedef struct packed {
    logic [1:0]      txClkSync, txFeSync, rxClkSync, rxFeSync;
    logic            txClkPrev, rxClkPrev, txInFrame, rxInFrame;
    logic [3:0]      txLen, rxLen, compLen, outLen, bitCnt;
    atpc_rate_t      txReqRate;
    atpc_rate_t [3:0] rateHist;
    logic [7:0]      compWord, outWord, shiftWord;
    atpc_tx_t        txState;
    logic            serOut, serOutEn_n;
    logic [1:0]      rxRate, ioMode;
    logic            pumpEn, delaySel, hpfBypass, linFmt, monSel;
    logic [2:0]      gain;
    logic [7:0]      result;
    logic [9:0]      divCnt;
    logic            convTick, pumpPhase, pumpTick;
    logic [19:0]     frameTimer;
    logic            frameMissing;
    logic [31:0]     prdata;
    logic            pready, pslverr;
  } atpc_state_t;
  atpc_state_t st_reg, st_next;

  logic       fifoValid, fifoPop;
  logic [7:0] fifoData;

  atpc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) sampleFifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (sampleValid),
    .inData   (sampleData),
    .inReady  (sampleReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  logic txRise, txFall, rxRise, txStart, txEnd, rxEnd, apbWrite;
  logic [2:0] txMap, rxMap;
  atpc_rate_t usedRate;
  logic [7:0] regIdx;
  logic [31:0] rdVal;
  logic rdOk;

  assign txRise   = st_reg.txClkSync[1] && !st_reg.txClkPrev;
  assign txFall   = !st_reg.txClkSync[1] && st_reg.txClkPrev;
  assign rxRise   = st_reg.rxClkSync[1] && !st_reg.rxClkPrev;
  assign txStart  = txRise && st_reg.txFeSync[1] && !st_reg.txInFrame;
  assign txEnd    = txRise && !st_reg.txFeSync[1] && st_reg.txInFrame;
  assign rxEnd    = rxRise && !st_reg.rxFeSync[1] && st_reg.rxInFrame;
  assign txMap    = atpcLenToRate(st_reg.txLen);
  assign rxMap    = atpcLenToRate(st_reg.rxLen);
  assign fifoPop  = txEnd;
  assign apbWrite = psel && penable && pwrite && st_reg.pready;
  assign regIdx   = {2'h0, paddr[7:2]};

  // Rate info alone passes the delay line; samples are taken undelayed
  always_comb begin
    usedRate = txMap[2] ? st_reg.txReqRate : atpc_rate_t'(txMap[1:0]);
    if (st_reg.delaySel) begin
      usedRate = st_reg.rateHist[3];
    end
  end

  always_comb begin
    rdVal = '0;
    rdOk  = paddr[1:0] == 2'h0;
    case (regIdx)
      8'(REG_IO_MODE): rdVal = 32'({st_reg.ioMode, 2'h0, st_reg.pumpEn});
      8'(REG_GAIN):    rdVal = 32'(st_reg.gain);
      8'(REG_DELAY):   rdVal = 32'({st_reg.delaySel, 5'h00});
      8'(REG_FILTER):  rdVal = 32'({st_reg.linFmt, st_reg.hpfBypass, 4'h0});
      8'(REG_RESULT):  rdVal = 32'(st_reg.result);
      8'(REG_STATUS):  rdVal = 32'({fifoValid, st_reg.frameMissing, st_reg.rxRate, st_reg.txReqRate});
      default:         rdOk = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.txClkSync = {st_reg.txClkSync[0], txBitClock};
    st_next.txFeSync  = {st_reg.txFeSync[0], txFrameEnable};
    st_next.rxClkSync = {st_reg.rxClkSync[0], rxBitClock};
    st_next.rxFeSync  = {st_reg.rxFeSync[0], rxFrameEnable};
    st_next.txClkPrev = st_reg.txClkSync[1];
    st_next.rxClkPrev = st_reg.rxClkSync[1];

    // Enable length measured in bit-clock rising edges
    if (txRise && st_reg.txFeSync[1]) begin
      st_next.txInFrame = 1'b1;
      st_next.txLen = st_reg.txInFrame ? st_reg.txLen + 4'h1 : 4'h1;
      if (st_reg.txLen == 4'hF) st_next.txLen = st_reg.txLen;
    end
    if (txEnd) begin
      st_next.txInFrame = 1'b0;
      if (!txMap[2]) st_next.txReqRate = atpc_rate_t'(txMap[1:0]);
      st_next.rateHist = {st_reg.rateHist[2:0], st_next.txReqRate};
      st_next.outWord = st_reg.compWord;
      st_next.outLen = st_reg.compLen;
      st_next.compWord = fifoValid ? fifoData : QUIET_WORD;
      st_next.compLen = atpcRateLen(usedRate);
    end
    if (rxRise && st_reg.rxFeSync[1]) begin
      st_next.rxInFrame = 1'b1;
      st_next.rxLen = st_reg.rxInFrame ? st_reg.rxLen + 4'h1 : 4'h1;
      if (st_reg.rxLen == 4'hF) st_next.rxLen = st_reg.rxLen;
    end
    if (rxEnd) begin
      st_next.rxInFrame = 1'b0;
      if (!rxMap[2]) st_next.rxRate = rxMap[1:0];
    end

    // Word driven from frame start; release ignores an early enable drop
    case (st_reg.txState)
      TX_IDLE: begin
        st_next.serOutEn_n = 1'b1;
        if (txStart) begin
          st_next.txState = TX_DRIVE;
          st_next.shiftWord = st_reg.outWord;
          st_next.serOut = st_reg.outWord[7];
          st_next.bitCnt = st_reg.outLen;
          st_next.serOutEn_n = 1'b0;
        end
      end
      TX_DRIVE: begin
        if (txRise) begin
          st_next.shiftWord = {st_reg.shiftWord[6:0], 1'b0};
          st_next.serOut = st_reg.shiftWord[6];
        end
        if (txFall) begin
          st_next.bitCnt = st_reg.bitCnt - 4'h1;
          if (st_reg.bitCnt <= 4'h1) begin
            st_next.txState = TX_IDLE;
            st_next.serOutEn_n = 1'b1;
          end
        end
      end
      default: begin
        st_next.txState = TX_IDLE;
        st_next.serOutEn_n = 1'b1;
      end
    endcase

    // Missing frames flagged until the next one arrives
    if (txStart) begin
      st_next.frameTimer = '0;
      st_next.frameMissing = 1'b0;
    end else if (st_reg.frameTimer == 20'(FRAME_LIMIT)) begin
      st_next.frameMissing = 1'b1;
    end else begin
      st_next.frameTimer = st_reg.frameTimer + 20'h1;
    end

    // Converter tick at 512 kHz, pump tick every second one
    st_next.convTick = 1'b0;
    st_next.pumpTick = 1'b0;
    if (st_reg.divCnt == 10'(CONV_DIV - 1)) begin
      st_next.divCnt = '0;
      st_next.convTick = 1'b1;
      st_next.pumpPhase = !st_reg.pumpPhase;
      st_next.pumpTick = st_reg.pumpPhase && st_reg.pumpEn;
    end else begin
      st_next.divCnt = st_reg.divCnt + 10'h1;
    end

    if (adcValid && st_reg.ioMode == IO_MODE_MONITOR) begin
      st_next.result = {1'b0, adcMagnitude};
    end

    // Registered answer: pready rises in the first access cycle
    st_next.pready = psel && !penable;
    st_next.pslverr = psel && !penable && !rdOk;
    if (psel && !penable) st_next.prdata = (rdOk && !pwrite) ? rdVal : 32'h0000_0000;
    if (apbWrite && rdOk) begin
      case (regIdx)
        8'(REG_IO_MODE): begin
          st_next.pumpEn = pwdata[PUMP_EN_BIT];
          st_next.ioMode = pwdata[IO_MODE_LSB +: 2];
        end
        8'(REG_GAIN):   st_next.gain = pwdata[GAIN_LSB +: 3];
        8'(REG_DELAY):  st_next.delaySel = pwdata[DELAY_BIT];
        8'(REG_FILTER): begin
          st_next.hpfBypass = pwdata[HPF_BYPASS_BIT];
          st_next.linFmt = pwdata[LINEAR_BIT];
        end
        default: st_next.result = st_next.result;
      endcase
    end
    st_next.monSel = st_next.ioMode == IO_MODE_MONITOR;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.txState <= TX_IDLE;
      st_reg.serOutEn_n <= 1'b1;
      st_reg.pumpEn <= PUMP_EN_RESET;
      st_reg.compWord <= QUIET_WORD;
      st_reg.outWord <= QUIET_WORD;
      st_reg.compLen <= LEN64;
      st_reg.outLen <= LEN64;
      st_reg.txReqRate <= RATE64;
      st_reg.rateHist <= {4{RATE64}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign txSerialOut      = st_reg.serOut;
  assign txSerialOutEn_n  = st_reg.serOutEn_n;
  assign pumpEnable       = st_reg.pumpEn;
  assign pumpClkEn        = st_reg.pumpTick;
  assign convClkEn        = st_reg.convTick;
  assign txTrimGain       = st_reg.gain;
  assign hpfBypass        = st_reg.hpfBypass;
  assign linearFormat     = st_reg.linFmt;
  assign supplyMonitorSel = st_reg.monSel;
  assign rxRate           = st_reg.rxRate;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_RELEASE: assert property (st_reg.txState == TX_DRIVE && txFall && st_reg.bitCnt == 4'h1
    |=> txSerialOutEn_n && st_reg.txState == TX_IDLE) else $error("Driver not released after word");
  AST_DRIVE_START: assert property (st_reg.txState == TX_IDLE && txStart
    |=> !txSerialOutEn_n && txSerialOut == $past(st_reg.outWord[7])) else $error("Word not driven at frame");
  AST_IDLE_HIZ: assert property (st_reg.txState == TX_IDLE |-> txSerialOutEn_n)
    else $error("Output driven while idle");
  AST_CONV_GAP: assert property (convClkEn |=> !convClkEn [*8])
    else $error("Converter tick too close");
  AST_PUMP_OFF: assert property (!pumpEnable && !convClkEn |=> !pumpClkEn)
    else $error("Pump ticking while disabled");
  AST_GAIN_WRITE: assert property (apbWrite && paddr == 8'(REG_GAIN * 4)
    |=> txTrimGain == $past(pwdata[2:0])) else $error("Gain write lost");
  AST_RESULT: assert property (adcValid && supplyMonitorSel
    |=> st_reg.result == {1'b0, $past(adcMagnitude)}) else $error("Supply result wrong");
  AST_RATE64: assert property (txEnd && st_reg.txLen == LEN64 && !st_reg.delaySel
    |=> st_reg.compLen == LEN64 && st_reg.txReqRate == RATE64) else $error("Length 8 not 64 kbps");
  AST_PIPE: assert property (txEnd |=> st_reg.outWord == $past(st_reg.compWord))
    else $error("Word pipeline skipped");
  AST_QUIET: assert property (txEnd && !fifoValid |=> st_reg.compWord == QUIET_WORD)
    else $error("Quiet word not all ones");
endmodule

/* File: tb/atpc_highway.sv */
// Voice highway controller model: frames the transmit port and captures its words
`timescale 1ns/1ps

module atpc_highway (
  // Clock
  input  wire logic clk,
  // Frame pins towards the block
  output logic      bitClk,
  output logic      frameEn,
  // Serial data from the block
  input  wire logic sdo,
  input  wire logic sdoEn_n
);
  logic [7:0] word;
  logic       line;
  // Released line shows the inverse, so a sample taken after release is caught
  assign line = sdoEn_n ? ~sdo : sdo;
  int         nBits;
  int         nDrv;

  initial begin
    bitClk = 1'b0;
    frameEn = 1'b0;
    word = 8'h00;
    nBits = 0;
    nDrv = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nine bit-clock periods per frame so the longest word completes; 125 ns, 13 clk high
  task automatic frame(input int len, input bit early);
    word = 8'h00;
    nBits = 0;
    nDrv = 0;
    for (int i = 0; i <= 8; i++) begin
      @(posedge clk);
      bitClk <= 1'b1;
      frameEn <= (i < len);
      repeat (12) @(posedge clk);
      // Early drop lands before the falling edge of the last bit
      if (early && i == len - 1) begin
        frameEn <= 1'b0;
      end
      @(posedge clk);
      bitClk <= 1'b0;
      repeat (11) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bits are settled well before the falling edge
  always @(negedge bitClk) begin
    if (sdoEn_n === 1'b0) begin
      word = {word[6:0], line};
      nBits++;
    end
  end

  always @(posedge clk) begin
    if (sdoEn_n === 1'b0) begin
      nDrv++;
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the transmit port control block
`timescale 1ns/1ps

module testbench import atpc_pkg::*;;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        bitClk, frameEn, txSerialOut, txSerialOutEn_n;
  logic        sampleValid, sampleReady, adcValid;
  logic [7:0]  sampleData;
  logic [6:0]  adcMagnitude;
  logic        pumpEnable, pumpClkEn, convClkEn, hpfBypass, linearFormat, supplyMonitorSel;
  logic [2:0]  txTrimGain;
  logic [1:0]  rxRate;
  int          failures, n_checks, skip;
  bit          dly;
  logic [7:0]  fifoQ[$], popQ[$];
  int          lenQ[$], nQ[$];

  atpc_top dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txBitClock(bitClk), .txFrameEnable(frameEn), .txSerialOut(txSerialOut),
    .txSerialOutEn_n(txSerialOutEn_n), .rxBitClock(bitClk), .rxFrameEnable(frameEn),
    .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady),
    .adcValid(adcValid), .adcMagnitude(adcMagnitude), .pumpEnable(pumpEnable),
    .pumpClkEn(pumpClkEn), .convClkEn(convClkEn), .txTrimGain(txTrimGain), .hpfBypass(hpfBypass),
    .linearFormat(linearFormat), .supplyMonitorSel(supplyMonitorSel), .rxRate(rxRate)
  );

  atpc_highway hw (.clk(clk), .bitClk(bitClk), .frameEn(frameEn), .sdo(txSerialOut),
    .sdoEn_n(txSerialOutEn_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // One idle cycle after each transfer keeps drivers to one change per step
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 19) begin
        failures++;
        tally_and_finish();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] ex, input logic ee, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r === ex && e === ee, m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdChk(8'h00, 32'h0000_0001, 1'b0, "io mode reset");
    wr(8'h04, 32'h0000_0005);
    chk(txTrimGain === 3'h5, "trim gain");
    rdChk(8'h04, 32'h0000_0005, 1'b0, "gain readback");
    wr(8'h20, 32'h0000_0030);
    chk(hpfBypass === 1'b1 && linearFormat === 1'b1, "filter format");
    wr(8'h20, 32'h0000_0010);
    chk(hpfBypass === 1'b1 && linearFormat === 1'b0, "hpf only");
    wr(8'h08, 32'h0000_00FF);
    rdChk(8'h08, 32'h0000_0000, 1'b1, "unmapped");
    rdChk(8'h02, 32'h0000_0000, 1'b1, "misaligned");
  endtask

  task automatic t_mon;
    wr(8'h00, 32'h0000_0009);
    chk(supplyMonitorSel === 1'b1, "monitor select");
    for (int i = 0; i < 2; i++) begin
      adcMagnitude <= i ? 7'h15 : 7'h7F;
      adcValid <= 1'b1;
      @(posedge clk);
      adcValid <= 1'b0;
      @(posedge clk);
      rdChk(8'h24, i ? 32'h0000_0015 : 32'h0000_007F, 1'b0, "supply result");
    end
    wr(8'h00, 32'h0000_0001);
  endtask

  task automatic t_clk;
    int np;
    int nc;
    np = 0;
    nc = 0;
    repeat (7800) begin
      @(posedge clk);
      np += (pumpClkEn === 1'b1);
      nc += (convClkEn === 1'b1);
    end
    chk(np >= 9 && np <= 11, "pump clock rate");
    chk(nc >= 19 && nc <= 21, "converter clock rate");
    wr(8'h00, 32'h0000_0000);
    np = 0;
    repeat (1600) begin
      @(posedge clk);
      np += (pumpClkEn === 1'b1);
    end
    chk(np == 0 && pumpEnable === 1'b0, "pump off");
    wr(8'h00, 32'h0000_0001);
  endtask

  // Far side drains only once a frame, so the fill side meets a full buffer
  task automatic t_fifo;
    sampleData <= 8'hC3;
    sampleValid <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      if (sampleReady === 1'b1) begin
        fifoQ.push_back(sampleData);
        sampleData <= sampleData + 8'h1B;
      end
    end
    sampleValid <= 1'b0;
    chk(fifoQ.size() == 8 && sampleReady === 1'b0, "fifo full");
  endtask

  function automatic logic [1:0] rateOf(input int len);
    return len == 2 ? 2'h0 : len == 3 ? 2'h1 : len == 4 ? 2'h2 : 2'h3;
  endfunction

  task automatic runF(input int len, input bit early);
    int         k;
    int         n;
    logic [7:0] w;
    k = lenQ.size();
    lenQ.push_back(len);
    nQ.push_back(dly ? lenQ[k-4] : len);
    popQ.push_back(fifoQ.size() ? fifoQ.pop_front() : 8'hFF);
    hw.frame(len, early);
    repeat (300) @(posedge clk);
    chk(rxRate === rateOf(len), "rx rate");
    chk(txSerialOutEn_n === 1'b1, "output not released");
    if (k >= 2 && k >= skip) begin
      n = nQ[k-2];
      w = popQ[k-2];
      chk(hw.nBits == n && hw.word === (w >> (8 - n)), "tx word");
      chk(hw.nDrv >= 25 * n - 14 && hw.nDrv <= 25 * n - 10, "drive span");
    end
  endtask

  task automatic t_frames;
    int ls[10] = '{2, 3, 4, 8, 8, 2, 4, 3, 2, 8};
    rdChk(8'h28, 32'h0000_0023, 1'b0, "status");
    for (int i = 0; i < 10; i++) begin
      runF(ls[i], i[0]);
    end
    wr(8'h1C, 32'h0000_0020);
    t_fifo();
    dly = 1'b1;
    skip = lenQ.size() + 3;
    for (int i = 0; i < 10; i++) begin
      runF(ls[9 - i], i[0]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {sampleValid, sampleData, adcValid, adcMagnitude} = 17'h0;
    failures = 0;
    n_checks = 0;
    skip = 0;
    dly = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_mon();
    t_clk();
    t_fifo();
    t_frames();
    tally_and_finish();
  end
endmodule
